// [tw_eeprom_regs.svh]
// Constants for the three-wire serial memory link and its controller.
`ifndef TW_EEPROM_REGS_SVH
`define TW_EEPROM_REGS_SVH
`define CLK_NS 8
`define CLK_MHZ 125
`define SPIKE_NS 100
`define SPIKE_CYC ((`SPIKE_NS + `CLK_NS - 1) / `CLK_NS)
`define EW_TYP_MS 6
`define EW_MAX_MS 10
`define EW_TYP_CYC (`EW_TYP_MS * `CLK_MHZ * 1000)
`define EW_CNT_W 21
`define FAST_KHZ 125
`define SLOW_KHZ 2
`define FAST_Q_CYC (`CLK_MHZ * 1000 / (`FAST_KHZ * 4))
`define SLOW_Q_CYC (`CLK_MHZ * 1000 / (`SLOW_KHZ * 4))
`define Q_CNT_W 14
`define MEM_WORDS 128
`define OFF_CTRL 8'h00
`define OFF_TXD 8'h04
`define OFF_CMD 8'h08
`define OFF_STATUS 8'h0c
`define CTRL_SLOW 0
`define CMD_OP_LSB 0
`define CMD_OP_MSB 1
`define CMD_NACK 2
`define ST_BUSY 0
`define ST_NACK 1
`define ST_IDLE 2
`define ST_RX_LSB 8
`define ST_RX_MSB 15
`endif

// [tw_pkg.sv]
// Types shared by both ends of the three-wire link.
package tw_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_wadr, st_wdata, st_read
  } slave_state_e;
  typedef enum logic [1:0] {
    op_start, op_stop, op_write, op_read
  } op_e;
endpackage : tw_pkg

// [tw_bus.sv]
// Interface joining the bus master and the memory slave.
`timescale 1ns/100ps
interface tw_bus;
  logic scl_o;
  logic scl_oe;
  logic sen_o;
  logic sen_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic start_stop_line;
  logic sda;
  // Open-drain lines with pull-ups resolve as a wired-and.
  assign scl = scl_oe ? scl_o : 1'b1;
  assign start_stop_line = sen_oe ? sen_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport master (
    output scl_o, scl_oe, sen_o, sen_oe, sda_m_o, sda_m_oe,
    input scl, start_stop_line, sda
  );
  modport slave (
    output sda_s_o, sda_s_oe,
    input scl, start_stop_line, sda
  );
endinterface : tw_bus

// [line_filter.sv]
// Synchroniser and spike filter for the three bus lines.
`timescale 1ns/100ps
`include "tw_eeprom_regs.svh"
module line_filter (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Raw and filtered lines, order clock, start line, data
  input wire logic [2:0] raw,
  output logic [2:0] clean
);
  localparam logic [3:0] SPIKE_LAST = 4'(`SPIKE_CYC - 1);
  logic [2:0] s1;
  logic [2:0] s2;
  logic [3:0] cnt [3];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 3'h7;
      s2 <= 3'h7;
    end else if (clk_en) begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  // A level must hold longer than the widest spike before it is taken.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clean <= 3'h7;
      for (int i = 0; i < 3; i++) begin
        cnt[i] <= 4'h0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < 3; i++) begin
        if (s2[i] == clean[i]) begin
          cnt[i] <= 4'h0;
        end else if (cnt[i] == SPIKE_LAST) begin
          clean[i] <= s2[i];
          cnt[i] <= 4'h0;
        end else begin
          cnt[i] <= cnt[i] + 4'h1;
        end
      end
    end
  end
endmodule : line_filter

// [eeprom_slave.sv]
// Memory end of the three-wire link: chip decode, read, timed write.
`timescale 1ns/100ps
`include "tw_eeprom_regs.svh"
module eeprom_slave #(
  parameter int unsigned EW_CYCLES = `EW_TYP_CYC,
  // Device-type code; the value is arbitrary.
  parameter logic [3:0] DEV_TYPE = 4'h6
) (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // Strap pins
  input wire logic select_pin_first,
  input wire logic select_pin_second,
  input wire logic mode_select_pin,
  // Status
  output logic ew_busy,
  // Bus
  tw_bus.slave bus
);
  localparam logic [`EW_CNT_W-1:0] EW_LOAD = EW_CYCLES[`EW_CNT_W-1:0];
  localparam logic [`EW_CNT_W-1:0] EW_ONE = `EW_CNT_W'(1);
  localparam logic [`EW_CNT_W-1:0] EW_ZERO = `EW_CNT_W'(0);

  logic [2:0] line;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic scl_q;
  logic sen_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  tw_pkg::slave_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [6:0] addr;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [`EW_CNT_W-1:0] ew_cnt;
  logic ew_busy_q;
  logic sda_oe;
  logic byte_end;
  logic take_data;
  logic dummy_end;
  logic abort_ew;
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem [`MEM_WORDS];

  function automatic logic chip_match(input logic [7:0] b,
                                      input logic [2:0] st);
    // Bit order sent: type, zero, second select, first select, direction.
    chip_match = (b[7:4] == DEV_TYPE) && !b[3]
                 && (b[1] == st[0]) && (b[2] == st[1]);
  endfunction : chip_match

  line_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .raw({bus.scl, bus.start_stop_line, bus.sda}),
    .clean(line)
  );

  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe;
  assign ew_busy = ew_busy_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      scl_q <= 1'b1;
      sen_q <= 1'b1;
    end else if (clk_en) begin
      strap_s1 <= {mode_select_pin, select_pin_second, select_pin_first};
      strap_s2 <= strap_s1;
      scl_q <= line[2];
      sen_q <= line[1];
    end
  end

  // Only the start line marks frames; data moving with clock high is
  // ignored, which keeps tied data and start lines usable.
  assign start_ev = sen_q && !line[1] && scl_q && line[2];
  assign stop_ev = !sen_q && line[1] && scl_q && line[2];
  assign scl_rise = !scl_q && line[2];
  assign scl_fall = scl_q && !line[2];
  assign byte_end = scl_fall && bit_cnt == 4'h7;
  assign take_data = byte_end && state == tw_pkg::st_wdata
                     && !ew_busy_q;
  assign dummy_end = byte_end && state == tw_pkg::st_wdata && ew_busy_q
                     && ew_cnt == EW_ZERO;
  assign abort_ew = byte_end && state == tw_pkg::st_addr && !strap_s2[2]
                    && chip_match(shift, strap_s2);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= tw_pkg::st_idle;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      addr <= 7'h00;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      if (start_ev) begin
        state <= tw_pkg::st_addr;
        // The clock fall that ends the start is not a data bit, so the
        // count starts one below zero and wraps to zero on that fall.
        bit_cnt <= 4'hf;
        sda_oe <= 1'b0;
      end else if (stop_ev) begin
        state <= tw_pkg::st_idle;
        sda_oe <= 1'b0;
      end else if (state != tw_pkg::st_idle) begin
        if (scl_rise) begin
          if (bit_cnt != 4'h8) begin
            shift <= {shift[6:0], line[0]};
          end else if (state == tw_pkg::st_read && line[0]) begin
            state <= tw_pkg::st_idle;
          end
        end else if (byte_end) begin
          bit_cnt <= 4'h8;
          case (state)
            tw_pkg::st_addr: begin
              if (chip_match(shift, strap_s2)) begin
                sda_oe <= 1'b1;
                state <= shift[0] ? tw_pkg::st_read : tw_pkg::st_wadr;
              end else begin
                state <= tw_pkg::st_idle;
              end
            end
            tw_pkg::st_wadr: begin
              addr <= shift[6:0];
              sda_oe <= 1'b1;
              state <= tw_pkg::st_wdata;
            end
            tw_pkg::st_wdata: begin
              // Busy is shown only by the missing acknowledge.
              sda_oe <= !ew_busy_q;
              if (!ew_busy_q) begin
                addr <= addr + 7'h01;
              end
            end
            default: begin
              sda_oe <= 1'b0;
            end
          endcase
        end else if (scl_fall) begin
          if (bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (state == tw_pkg::st_read) begin
              tx <= mem[addr];
              sda_oe <= !mem[addr][7];
              addr <= addr + 7'h01;
            end else begin
              sda_oe <= 1'b0;
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
            if (state == tw_pkg::st_read) begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= !tx[6];
            end
          end
        end
      end
    end
  end

  // Timed erase/write engine; the cell reads back as erased until the
  // count expires, and an abort leaves it erased.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ew_cnt <= EW_ZERO;
      ew_busy_q <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end else if (clk_en) begin
      if (abort_ew) begin
        ew_cnt <= EW_ZERO;
        ew_busy_q <= 1'b0;
      end else if (take_data) begin
        ew_cnt <= EW_LOAD;
        ew_busy_q <= 1'b1;
        wr_addr <= addr;
        wr_data <= shift;
      end else begin
        if (ew_cnt != EW_ZERO) begin
          ew_cnt <= ew_cnt - EW_ONE;
        end
        if (dummy_end) begin
          ew_busy_q <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    mem_we = 1'b0;
    mem_wa = wr_addr;
    mem_wd = wr_data;
    if (take_data) begin
      mem_we = 1'b1;
      mem_wa = addr;
      mem_wd = 8'hff;
    end else if (ew_cnt == EW_ONE && !abort_ew) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge hclk) begin
    if (clk_en && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
endmodule : eeprom_slave

// [tw_master.sv]
// Bus-master end: AHB-Lite registers driving start, stop and bytes.
`timescale 1ns/100ps
`include "tw_eeprom_regs.svh"
module tw_master #(
  parameter int unsigned FAST_Q = `FAST_Q_CYC,
  parameter int unsigned SLOW_Q = `SLOW_Q_CYC
) (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Bus
  tw_bus.master bus
);
  localparam logic [`Q_CNT_W-1:0] FAST_LAST = `Q_CNT_W'(FAST_Q - 1);
  localparam logic [`Q_CNT_W-1:0] SLOW_LAST = `Q_CNT_W'(SLOW_Q - 1);

  logic [2:0] line;
  logic a_valid;
  logic a_write;
  logic [7:0] a_addr;
  logic ctrl_slow;
  logic [7:0] txd;
  logic [7:0] tx_sh;
  logic [7:0] rx;
  logic nack_seen;
  logic nack_bit;
  tw_pkg::op_e op;
  logic run;
  logic [3:0] slot;
  logic [1:0] ph;
  logic [`Q_CNT_W-1:0] qcnt;
  logic tick;
  logic last;
  logic cmd_wr;
  logic scl_oe;
  logic sen_oe;
  logic sda_oe;
  logic [31:0] status;

  line_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .raw({bus.scl, bus.start_stop_line, bus.sda}),
    .clean(line)
  );

  assign bus.scl_o = 1'b0;
  assign bus.sen_o = 1'b0;
  assign bus.sda_m_o = 1'b0;
  assign bus.scl_oe = scl_oe;
  assign bus.sen_oe = sen_oe;
  assign bus.sda_m_oe = sda_oe;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    status = 32'h0;
    status[`ST_BUSY] = run;
    status[`ST_NACK] = nack_seen;
    status[`ST_IDLE] = line[2] && line[1];
    status[`ST_RX_MSB:`ST_RX_LSB] = rx;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_addr <= 8'h00;
      hrdata <= 32'h0;
      ctrl_slow <= 1'b0;
      txd <= 8'h00;
    end else if (clk_en) begin
      if (hready) begin
        a_valid <= hsel && htrans[1];
        a_write <= hwrite;
        a_addr <= haddr[7:0];
        hrdata <= 32'h0;
        if (hsel && htrans[1] && !hwrite) begin
          if (haddr[7:0] == `OFF_CTRL) begin
            hrdata <= {31'h0, ctrl_slow};
          end else if (haddr[7:0] == `OFF_TXD) begin
            hrdata <= {24'h0, txd};
          end else if (haddr[7:0] == `OFF_STATUS) begin
            hrdata <= status;
          end
        end
      end
      if (a_valid && a_write) begin
        if (a_addr == `OFF_CTRL) begin
          ctrl_slow <= hwdata[`CTRL_SLOW];
        end else if (a_addr == `OFF_TXD) begin
          txd <= hwdata[7:0];
        end
      end
    end
  end

  assign cmd_wr = a_valid && a_write && a_addr == `OFF_CMD && !run;
  assign tick = run && qcnt == (ctrl_slow ? SLOW_LAST : FAST_LAST);
  assign last = (op == tw_pkg::op_start || op == tw_pkg::op_stop)
                ? slot == 4'h0 : slot == 4'h8;

  // Each slot is four quarter periods: set data, clock high, sample,
  // clock low (a stop leaves it high), so data only ever moves while the clock is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 1'b0;
      op <= tw_pkg::op_start;
      nack_bit <= 1'b0;
      slot <= 4'h0;
      ph <= 2'h0;
      qcnt <= `Q_CNT_W'(0);
      tx_sh <= 8'h00;
      rx <= 8'h00;
      nack_seen <= 1'b0;
      scl_oe <= 1'b0;
      sen_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (clk_en) begin
      if (cmd_wr) begin
        run <= 1'b1;
        op <= tw_pkg::op_e'(hwdata[`CMD_OP_MSB:`CMD_OP_LSB]);
        nack_bit <= hwdata[`CMD_NACK];
        tx_sh <= txd;
        slot <= 4'h0;
        ph <= 2'h0;
        qcnt <= `Q_CNT_W'(0);
      end else if (tick) begin
        qcnt <= `Q_CNT_W'(0);
        ph <= ph + 2'h1;
        case (ph)
          2'h0: begin
            case (op)
              tw_pkg::op_stop: begin
                sen_oe <= 1'b1;
                sda_oe <= 1'b0;
              end
              tw_pkg::op_write: begin
                sda_oe <= slot == 4'h8 ? 1'b0 : !tx_sh[7];
              end
              tw_pkg::op_read: begin
                sda_oe <= slot == 4'h8 ? !nack_bit : 1'b0;
              end
              default: begin
                sda_oe <= 1'b0;
              end
            endcase
          end
          2'h1: begin
            scl_oe <= 1'b0;
          end
          2'h2: begin
            if (op == tw_pkg::op_start) begin
              sen_oe <= 1'b1;
            end else if (op == tw_pkg::op_stop) begin
              sen_oe <= 1'b0;
            end else if (op == tw_pkg::op_write && slot == 4'h8) begin
              nack_seen <= line[0];
            end else if (op == tw_pkg::op_read && slot != 4'h8) begin
              rx <= {rx[6:0], line[0]};
            end
          end
          default: begin
            if (op != tw_pkg::op_stop) begin
              scl_oe <= 1'b1;
            end
            tx_sh <= {tx_sh[6:0], 1'b0};
            slot <= slot + 4'h1;
            if (op == tw_pkg::op_read && slot == 4'h8) begin
              sda_oe <= 1'b0;
            end
            if (last) begin
              run <= 1'b0;
              if (op == tw_pkg::op_start) begin
                sen_oe <= 1'b0;
              end
            end
          end
        endcase
      end else if (run) begin
        qcnt <= qcnt + `Q_CNT_W'(1);
      end
    end
  end
endmodule : tw_master

// [tw_link_asserts.sv]
// Wire-level checks on the three-wire link between both ends.
`timescale 1ns/100ps
module tw_link_asserts (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Resolved lines
  input wire logic scl,
  input wire logic start_stop_line,
  input wire logic sda,
  // Memory end drive
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  logic scl_q;
  logic sen_q;
  logic [3:0] rises;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sen_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sen_q <= start_stop_line;
    end
  end
  // Clock pulses since the last start; saturates so idle never wraps.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rises <= 4'hf;
    end else if (sen_q && !start_stop_line && scl) begin
      rises <= 4'h0;
    end else if (scl && !scl_q && rises != 4'hf) begin
      rises <= rises + 4'h1;
    end
  end
  sequence s_start;
    $fell(start_stop_line) && scl;
  endsequence
  sequence s_stop;
    $rose(start_stop_line) && scl;
  endsequence
  a_start_hold: assert property (s_start |-> scl [*8])
    else $error("clock dropped right after start");
  a_start_free: assert property (s_start |-> sda && !sda_s_oe)
    else $error("data line held at start");
  a_stop_free: assert property (s_stop |-> sda && !sda_s_oe)
    else $error("data line held at stop");
  a_sda_steady: assert property (scl && $past(scl) && start_stop_line && $past(start_stop_line)
    |-> $stable(sda))
    else $error("data changed while clock high");
  a_drive_low: assert property (sda_s_oe |-> !sda_s_o)
    else $error("memory end drives data high");
  a_change_low: assert property ($changed(sda_s_oe)
    |-> !scl && !$past(scl) && !$past(scl, 8))
    else $error("memory end switched drive near clock high");
  a_drive_setup: assert property ($rose(sda_s_oe) |-> !scl [*8])
    else $error("memory drive too close to clock rise");
  a_chip_quiet: assert property ($rose(scl) && rises < 4'h8
    |-> !sda_s_oe)
    else $error("memory end drove during chip byte");
endmodule : tw_link_asserts

// [test_three_wire_serial_eeprom_slave.sv]
// Self-checking bench joining master and memory ends over the link.
`timescale 1ns/100ps
module test_three_wire_serial_eeprom_slave;
  // Device-type code; the value is arbitrary.
  localparam logic [3:0] DEV = 4'h6;
  localparam int unsigned EW = 2000;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic sel1 = 1'b1;
  logic sel2 = 1'b0;
  logic mode = 1'b1;
  logic ew_busy;
  logic [31:0] st;
  int n_mismatch = 0;
  int check_count = 0;
  tw_bus bus ();
  assign hready = hreadyout;
  // Short quarter-bits keep the run brief yet above the filter delay.
  tw_master #(.FAST_Q(40), .SLOW_Q(64)) tw_master_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bus(bus));
  eeprom_slave #(.EW_CYCLES(EW), .DEV_TYPE(DEV)) eeprom_slave_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .select_pin_first(sel1), .select_pin_second(sel2),
    .mode_select_pin(mode), .ew_busy(ew_busy), .bus(bus));
  tw_link_asserts tw_link_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .scl(bus.scl), .start_stop_line(bus.start_stop_line),
    .sda(bus.sda), .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe));
  always #4 hclk = ~hclk;
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits are open ended; a hang is caught by the watchdog alone.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    st = hrdata;
  endtask : ahb
  // Software must see busy low before the next command, else it is lost.
  task op(input logic [2:0] c);
    ahb(1'b1, 8'h08, {29'h0, c});
    ahb(1'b0, 8'h0c, 32'h0);
    while (st[0] !== 1'b0) begin
      ahb(1'b0, 8'h0c, 32'h0);
    end
  endtask : op
  task begin_frame;
    op({1'b0, tw_pkg::op_start});
  endtask : begin_frame
  task end_frame;
    op({1'b0, tw_pkg::op_stop});
  endtask : end_frame
  task wr_byte(input logic [7:0] b, input logic nack);
    ahb(1'b1, 8'h04, {24'h0, b});
    op({1'b0, tw_pkg::op_write});
    chk({31'h0, st[1]}, {31'h0, nack});
  endtask : wr_byte
  task rd_byte(input logic nack, input logic [7:0] exp);
    op({nack, tw_pkg::op_read});
    chk({24'h0, st[15:8]}, {24'h0, exp});
  endtask : rd_byte
  task chk_busy(input logic exp);
    chk({31'h0, ew_busy}, {31'h0, exp});
  endtask : chk_busy
  function automatic logic [7:0] chip(input logic rw);
    return {DEV, 1'b0, sel2, sel1, rw};
  endfunction : chip
  task test_reset;
    ahb(1'b0, 8'h0c, 32'h0);
    chk(st & 32'h5, 32'h4);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    chk_busy(1'b0);
    ahb(1'b0, 8'h10, 32'h0);
    chk(st, 32'h0);
    ahb(1'b0, 8'h08, 32'h0);
    chk(st, 32'h0);
    $display("test_reset done");
  endtask : test_reset
  task test_write;
    begin_frame;
    wr_byte(chip(1'b0), 1'b0);
    wr_byte(8'h05, 1'b0);
    wr_byte(8'ha5, 1'b0);
    chk_busy(1'b1);
    wr_byte(8'h11, 1'b1);
    wr_byte(8'h11, 1'b1);
    wr_byte(8'h11, 1'b0);
    repeat (EW + 100) @(posedge hclk);
    wr_byte(8'h00, 1'b1);
    chk_busy(1'b0);
    end_frame;
    $display("test_write done");
  endtask : test_write
  task test_read;
    begin_frame;
    wr_byte(chip(1'b0), 1'b0);
    wr_byte(8'h05, 1'b0);
    begin_frame;
    wr_byte(chip(1'b1), 1'b0);
    rd_byte(1'b0, 8'ha5);
    rd_byte(1'b1, 8'h11);
    end_frame;
    $display("test_read done");
  endtask : test_read
  task test_select;
    logic m;
    logic [7:0] b;
    for (int i = 0; i < 5; i++) begin
      b = (i == 4) ? {~DEV, 4'h0} : {DEV, 1'b0, i[1:0], 1'b0};
      m = (i == 4) || (i[1:0] != {sel2, sel1});
      begin_frame;
      wr_byte(b, m);
      wr_byte(8'h3c, m);
      end_frame;
    end
    $display("test_select done");
  endtask : test_select
  task test_abort;
    mode <= 1'b0;
    begin_frame;
    wr_byte(chip(1'b0), 1'b0);
    wr_byte(8'h10, 1'b0);
    wr_byte(8'h3c, 1'b0);
    chk_busy(1'b1);
    begin_frame;
    wr_byte(chip(1'b0), 1'b0);
    chk_busy(1'b0);
    wr_byte(8'h11, 1'b0);
    wr_byte(8'h77, 1'b0);
    end_frame;
    begin_frame;
    wr_byte(chip(1'b0), 1'b0);
    end_frame;
    chk_busy(1'b0);
    mode <= 1'b1;
    $display("test_abort done");
  endtask : test_abort
  task test_slow;
    ahb(1'b1, 8'h00, 32'h1);
    begin_frame;
    wr_byte(chip(1'b0), 1'b0);
    wr_byte(8'h05, 1'b0);
    begin_frame;
    wr_byte(chip(1'b1), 1'b0);
    rd_byte(1'b1, 8'ha5);
    end_frame;
    ahb(1'b1, 8'h00, 32'h0);
    $display("test_slow done");
  endtask : test_slow
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset;
    test_write;
    test_read;
    test_select;
    test_abort;
    test_slow;
    complete_run;
  end
  // The tests need about 60000 cycles; the limit stays under 100000.
  initial begin
    #760000;
    n_mismatch++;
    $display("Watchdog expired at %0t ns", $time);
    complete_run;
  end
endmodule : test_three_wire_serial_eeprom_slave
